// ===== src/i2c_master_defs.svh
/*
  Register indices, byte addresses, bit positions and reset values of the I2C master.
  Assumes inclusion by bare name from design files that need these constants.
*/
`ifndef I2C_MASTER_DEFS_SVH
`define I2C_MASTER_DEFS_SVH

// Register indices; byte address is four times the index
`define CTRL_IDX 10'h0e1
`define DATA_IDX 10'h0e2
`define STAT_IDX 10'h0e3
`define MASK_IDX 10'h0e4
`define IEN_IDX 10'h0ea

// Control and irq enable register bit positions
`define ON_BIT 7
`define ACKSEL_BIT 6
`define DONE_BIT 5
`define ACKIN_BIT 4
`define START_BIT 3
`define STOP_BIT 2
`define IEN_BIT 7

// Status and mask bit positions
`define ST_DONE_BIT 0
`define ST_NACK_BIT 1

// Reset values
`define RATE_RST 2'h0
`define STOP_RST 1'h1

// Bit counter: eight data bits then the acknowledge slot
`define ACK_SLOT 4'h8

`endif

// ===== src/i2c_master_pkg.sv
/*
  Types shared by the I2C master modules.
  Assumes the compile order puts this file before its users.
*/
package i2c_master_pkg;

  // Bus sequencer states, Gray along idle-start-hold-byte-stop
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_HOLD = 3'h3,
    ST_BYTE = 3'h2,
    ST_STOP = 3'h6
  } seq_state_type;

  // Quarter phases of one SCL period
  typedef logic [1:0] phase_type;

endpackage : i2c_master_pkg

// ===== src/scl_tick_if.sv
/*
  Carrier between the sequencer and the SCL quarter-tick generator.
  Assumes both ends share pclk.
*/
interface scl_tick_if;
  logic [1:0] rate_sel; // Divider code from software
  logic run;            // Counter runs while high
  logic tick;           // One-cycle quarter-period pulse

  modport ctrl (output rate_sel, output run, input tick);
  modport gen (input rate_sel, input run, output tick);
endinterface : scl_tick_if

// ===== src/i2c_scl_tick.sv
/*
  Quarter-period tick generator for SCL: Fsys/4, /16, /64, /256.
  Assumes pclk domain and asynchronous active-low reset.
*/
module i2c_scl_tick #(
  parameter int CNT_W = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequencer side
  scl_tick_if.gen tk
);

  logic [CNT_W-1:0] cnt_q; // Cycles within the current quarter
  logic tick_q;            // Registered pulse

  // Last count of a quarter: 0, 3, 15 or 63, for quarters of 1, 4, 16 or 64 cycles
  function automatic logic [CNT_W-1:0] quarter_last(input logic [1:0] code);
    logic [CNT_W-1:0] v;
    v = CNT_W'((1 << (2 * code)) - 1);
    return v;
  endfunction : quarter_last

  // Counter restarts when idle so the first quarter is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (!tk.run) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q >= quarter_last(tk.rate_sel)) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign tk.tick = tick_q;

endmodule : i2c_scl_tick

// ===== src/i2c_master_controller.sv
/*
  Byte-oriented I2C master behind an APB slave: control, shift data,
  interrupt status, mask and enable registers, open-drain SCL and SDA.
  Assumes a single pclk domain; bus pins arrive asynchronously and are
  synchronised here; an external pull-up resolves the open-drain lines.
*/
// The APB register port was left to the implementer.
// Operation
// - Controller works only while enable bit set
// - Receive acknowledge slot drives selected ACK/NACK
// - Each finished byte sets done flag
// - Writing zero clears done flag
// - Slave acknowledge captured in read-only bit
// - Start bit launches START condition
// - Stop bit sends STOP; reads one after reset
// - Rate code divides system clock 4..256
// - Data register shifts bytes out and in
// - Data write resumes transmit between START/STOP
// - Data read resumes receive between START/STOP
// - Interrupt raised only when enable bit set
`include "i2c_master_defs.svh"

module i2c_master_controller (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // I2C clock line, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // I2C data line, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt
  output logic irq
);

  // Control, data, irq enable, status and mask register fields
  logic on_q;          // controller_on
  logic ack_sel_q;     // ack_out_select
  logic done_q;        // byte_done_flag
  logic ack_in_q;      // ack_in_status
  logic start_q;       // start_request
  logic stop_q;        // stop_request
  logic [1:0] rate_q;  // scl_rate_select
  logic [7:0] shift_q; // master_shift_reg
  logic irq_en_q;      // byte_done_irq_en
  logic [1:0] stat_q;  // Sticky events, cleared by read
  logic [1:0] mask_q;  // Event mask, same layout

  // Sequencer
  i2c_master_pkg::seq_state_type state_q;
  i2c_master_pkg::phase_type phase_q;
  logic [3:0] bit_q;   // Bit within byte, 8 is the acknowledge slot
  logic rx_q;          // Current byte is a receive

  // Pin synchronisers and drivers
  logic scl_m_q, scl_s_q; // First stage read only by second
  logic sda_m_q, sda_s_q;
  logic scl_oe_q, sda_oe_q;
  logic scl_d, sda_d;

  // APB answer and interrupt registers
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;

  // Tick generator link
  scl_tick_if tk ();

  i2c_scl_tick #(.CNT_W(6)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );

  assign tk.rate_sel = rate_q;
  assign tk.run = on_q && (state_q != i2c_master_pkg::ST_IDLE || start_q);

  // Address decode of the word index
  function automatic logic idx_hit(input logic [11:0] a, input logic [9:0] idx);
    return a[11:2] == idx;
  endfunction : idx_hit

  logic hit_ctrl, hit_data, hit_stat, hit_mask, hit_ien, hit_any;
  assign hit_ctrl = idx_hit(paddr, `CTRL_IDX);
  assign hit_data = idx_hit(paddr, `DATA_IDX);
  assign hit_stat = idx_hit(paddr, `STAT_IDX);
  assign hit_mask = idx_hit(paddr, `MASK_IDX);
  assign hit_ien = idx_hit(paddr, `IEN_IDX);
  assign hit_any = hit_ctrl | hit_data | hit_stat | hit_mask | hit_ien;

  // Access edge: the one where pready is seen high
  logic acc, wr, rd;
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  // Sequencer events
  logic adv, last_ph, in_hold, byte_end, go_tx, go_rx, stop_pend;
  // Phase 2 waits for SCL really high so a stretching slave is honoured
  assign adv = tk.tick && (phase_q != 2'h2 || scl_s_q);
  assign last_ph = adv && phase_q == 2'h3;
  assign in_hold = state_q == i2c_master_pkg::ST_HOLD;
  assign byte_end = last_ph && state_q == i2c_master_pkg::ST_BYTE && bit_q == `ACK_SLOT;
  assign go_tx = wr && hit_data && in_hold;
  assign go_rx = rd && hit_data && in_hold;
  assign stop_pend = stop_q && state_q != i2c_master_pkg::ST_IDLE;

  // Read mux for the answer phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux[7:0] = {on_q, ack_sel_q, done_q, ack_in_q, start_q, stop_q, rate_q};
    end else if (hit_data) begin
      rd_mux[7:0] = shift_q;
    end else if (hit_stat) begin
      rd_mux[1:0] = stat_q;
    end else if (hit_mask) begin
      rd_mux[1:0] = mask_q;
    end else if (hit_ien) begin
      rd_mux[`IEN_BIT] = irq_en_q;
    end
  end

  // APB answer one cycle into the access phase; unmapped gives an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? rd_mux : 32'h0;
      pslverr_q <= psel && penable && !pready_q && !hit_any;
    end
  end

  // Software-owned control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 1'b0;
      ack_sel_q <= 1'b0;
      rate_q <= `RATE_RST;
      irq_en_q <= 1'b0;
      mask_q <= 2'h0;
    end else begin
      if (wr && hit_ctrl) begin
        on_q <= pwdata[`ON_BIT];
        ack_sel_q <= pwdata[`ACKSEL_BIT];
        rate_q <= pwdata[1:0];
      end
      if (wr && hit_ien) begin
        irq_en_q <= pwdata[`IEN_BIT];
      end
      if (wr && hit_mask) begin
        mask_q <= pwdata[1:0];
      end
    end
  end

  // Start request: set by software, cleared once START is on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
    end else if (last_ph && state_q == i2c_master_pkg::ST_START) begin
      start_q <= 1'b0;
    end else if (wr && hit_ctrl && pwdata[`START_BIT]) begin
      start_q <= 1'b1;
    end
  end

  // Stop request: reads one while the bus is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_q <= `STOP_RST;
    end else if (state_q == i2c_master_pkg::ST_IDLE && on_q && start_q) begin
      stop_q <= 1'b0;
    end else if (wr && hit_ctrl && pwdata[`STOP_BIT]) begin
      stop_q <= 1'b1;
    end
  end

  // Done flag: hardware set wins over a write of zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (byte_end) begin
      done_q <= 1'b1;
    end else if (wr && hit_ctrl && !pwdata[`DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // Sticky status: read clears, a same-cycle event survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 2'h0;
    end else begin
      if (rd && hit_stat) begin
        stat_q <= 2'h0;
      end
      if (byte_end) begin
        stat_q[`ST_DONE_BIT] <= 1'b1;
      end
      if (byte_end && !rx_q && ack_in_q) begin
        stat_q[`ST_NACK_BIT] <= 1'b1;
      end
    end
  end

  // Interrupt level, gated by the enable bit and the mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_en_q && |(stat_q & mask_q);
    end
  end

  // Two-flop synchronisers on the bus pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
    end
  end

  // Shift register: software load, bus sample in the high phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 8'h0;
    end else if (wr && hit_data && state_q != i2c_master_pkg::ST_BYTE) begin
      shift_q <= pwdata[7:0];
    end else if (adv && phase_q == 2'h2 && state_q == i2c_master_pkg::ST_BYTE
                 && bit_q != `ACK_SLOT) begin
      shift_q <= {shift_q[6:0], sda_s_q};
    end
  end

  // Slave acknowledge after a transmitted byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_in_q <= 1'b0;
    end else if (adv && phase_q == 2'h2 && state_q == i2c_master_pkg::ST_BYTE
                 && bit_q == `ACK_SLOT && !rx_q) begin
      ack_in_q <= sda_s_q;
    end
  end

  // Phase and bit counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 2'h0;
      bit_q <= 4'h0;
    end else if (state_q == i2c_master_pkg::ST_IDLE || in_hold) begin
      phase_q <= 2'h0;
      bit_q <= 4'h0;
    end else if (adv) begin
      phase_q <= phase_q + 2'h1;
      if (last_ph) begin
        bit_q <= bit_q + 4'h1;
      end
    end
  end

  // Bus sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= i2c_master_pkg::ST_IDLE;
      rx_q <= 1'b0;
    end else if (!on_q) begin
      state_q <= i2c_master_pkg::ST_IDLE;
    end else begin
      case (state_q)
        i2c_master_pkg::ST_IDLE: begin
          if (start_q) begin
            state_q <= i2c_master_pkg::ST_START;
          end
        end
        i2c_master_pkg::ST_START: begin
          if (last_ph) begin
            state_q <= i2c_master_pkg::ST_HOLD;
          end
        end
        // Waits with SCL low; a repeated START or STOP outranks data
        i2c_master_pkg::ST_HOLD: begin
          if (start_q) begin
            state_q <= i2c_master_pkg::ST_START;
          end else if (stop_pend) begin
            state_q <= i2c_master_pkg::ST_STOP;
          end else if (go_tx) begin
            state_q <= i2c_master_pkg::ST_BYTE;
            rx_q <= 1'b0;
          end else if (go_rx) begin
            state_q <= i2c_master_pkg::ST_BYTE;
            rx_q <= 1'b1;
          end
        end
        i2c_master_pkg::ST_BYTE: begin
          if (byte_end) begin
            state_q <= i2c_master_pkg::ST_HOLD;
          end
        end
        i2c_master_pkg::ST_STOP: begin
          if (last_ph) begin
            state_q <= i2c_master_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= i2c_master_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Pull-down enables per state and quarter phase; SDA moves only in
  // low phases, except the START and STOP edges themselves
  logic bit_pull;
  always_comb begin
    scl_d = 1'b0;
    sda_d = 1'b0;
    if (bit_q == `ACK_SLOT) begin
      bit_pull = rx_q && !ack_sel_q;
    end else begin
      bit_pull = !rx_q && !shift_q[7];
    end
    case (state_q)
      i2c_master_pkg::ST_IDLE: begin
        scl_d = 1'b0;
        sda_d = 1'b0;
      end
      i2c_master_pkg::ST_START: begin
        scl_d = (phase_q == 2'h0) ? scl_oe_q : (phase_q == 2'h3);
        sda_d = phase_q >= 2'h2;
      end
      i2c_master_pkg::ST_HOLD: begin
        scl_d = 1'b1;
        sda_d = sda_oe_q;
      end
      i2c_master_pkg::ST_BYTE: begin
        scl_d = phase_q == 2'h0 || phase_q == 2'h3;
        // SDA holds while SCL falls, so a slave never sees a false START
        sda_d = (phase_q == 2'h3) ? sda_oe_q : bit_pull;
      end
      i2c_master_pkg::ST_STOP: begin
        scl_d = phase_q == 2'h0;
        sda_d = phase_q <= 2'h1;
      end
      default: begin
        scl_d = 1'b0;
        sda_d = 1'b0;
      end
    endcase
  end

  // Registered pin drivers; released while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= on_q && scl_d;
      sda_oe_q <= on_q && sda_d;
    end
  end

  // Outputs straight from flip-flops; open-drain data is always low
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign irq = irq_q;

endmodule : i2c_master_controller

// ===== verification/i2c_slave_model.sv
/*
  Behavioural I2C slave on the resolved open-drain lines: acks written bytes,
  sends a fixed byte on request, may stretch SCL after each falling edge.
  Assumes the bench resolves both lines with a pull-up.
*/
module i2c_slave_model (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Bench controls
  input wire logic send,
  input wire logic nack,
  input wire logic stretch,
  input wire logic [7:0] tx_byte,
  // Line pulls
  output logic sda_low,
  output logic scl_low,
  // Observations
  output logic [7:0] rx_byte,
  output logic ack_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int bitn; // Bits clocked in this byte
  int slot; // Slot driven while SCL is low
  // Idle state
  initial begin
    bitn = 0;
    slot = 9;
    rx_byte = 8'h0;
    ack_seen = 1'h0;
    scl_low = 1'h0;
  end
  // Edge of SDA with SCL high frames the transfer
  always @(sda) begin
    if (scl === 1'h1) begin
      bitn = 0;
      slot = 9;
      ack_seen = 1'h0;
    end
  end
  // Sample on the rising edge; master ack only counts when we send
  always @(posedge scl) begin
    if (bitn < 8) rx_byte = {rx_byte[6:0], sda};
    else if (send) ack_seen = sda;
    bitn = (bitn == 8) ? 0 : bitn + 1;
  end
  // Change data only while SCL is low; stretching shows a slow slave
  always @(negedge scl) begin
    slot = bitn;
    if (stretch) begin
      scl_low = 1'h1;
      #40;
      scl_low = 1'h0;
    end
  end
  // After a master NACK the slave lets go so STOP can form
  assign sda_low = (slot < 8) ? (send && !ack_seen && !tx_byte[3'(7 - slot)])
                              : (slot == 8 && !send && !nack);
endmodule : i2c_slave_model

// ===== verification/i2c_master_controller_assertions.sv
/*
  Concurrent checks on the ports of the I2C master top module.
  Assumes the register constants header and a single pclk domain.
*/
`include "i2c_master_defs.svh"
module i2c_master_controller_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Lines and interrupt
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  logic on_q; // Last written enable bit
  logic ien_q; // Last written irq enable bit
  wire taken = psel && penable && pready; // Completed access
  wire ctrl_wr = taken && pwrite && paddr[11:2] == `CTRL_IDX;
  wire mapped = paddr[11:2] inside {`CTRL_IDX, `DATA_IDX, `STAT_IDX, `MASK_IDX, `IEN_IDX};
  // Shadow of the enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_q <= 1'h0;
    else if (ctrl_wr) on_q <= pwdata[`ON_BIT];
  end
  // Shadow of the irq enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ien_q <= 1'h0;
    else if (taken && pwrite && paddr[11:2] == `IEN_IDX) ien_q <= pwdata[`IEN_BIT];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Start from a disabled, idle bus at any rate code
  sequence start_req_s;
    ctrl_wr && !on_q && pwdata[`ON_BIT] && pwdata[`START_BIT] && !scl_oe && !sda_oe;
  endsequence
  sequence start_cond_s;
    sda_oe && !scl_oe;
  endsequence
  // Stop while SCL is held, fastest rate so the bound stays short
  sequence stop_req_s;
    ctrl_wr && on_q && pwdata[`STOP_BIT] && !pwdata[`START_BIT] && pwdata[1:0] == 2'h0 && scl_oe;
  endsequence
  a_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a single pulse one cycle into access");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (taken |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  a_irq_gate: assert property (irq |-> ien_q || $past(ien_q))
    else $error("irq raised while irq enable clear");
  a_open_drain: assert property (scl_out == 1'h0 && sda_out == 1'h0)
    else $error("line driven high");
  a_off_release: assert property (!on_q && !$past(on_q) |-> !scl_oe && !sda_oe)
    else $error("line pulled while disabled");
  a_start_launch: assert property (start_req_s |-> ##[1:600] start_cond_s)
    else $error("no START after start request");
  a_stop_release: assert property (stop_req_s |-> ##[1:200] ($fell(sda_oe) && !scl_oe))
    else $error("no STOP after stop request");
endmodule : i2c_master_controller_assertions

bind i2c_master_controller i2c_master_controller_assertions i2c_master_controller_assertions_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .scl_out, .scl_oe, .sda_out, .sda_oe, .irq);

// ===== verification/testbench.sv
/*
  Directed bench for the I2C master: APB tasks against a slave model.
  Assumes design, package, interface, checker and slave model compiled first.
*/
`include "i2c_master_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite; // APB controls
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd; // rd holds prdata of the last transfer
  logic pready, pslverr, err, scl_out, scl_oe, sda_out, sda_oe, irq;
  logic s_send, s_nack, s_stretch, s_sda_low, s_scl_low, s_ack; // Slave side
  logic [7:0] s_rx;
  int num_errors, check_count;
  time t_rise, scl_per, lo; // SCL period monitor
  // Open-drain lines with pull-up
  wire scl = !scl_oe && !s_scl_low;
  wire sda = !sda_oe && !s_sda_low;
  i2c_master_controller i2c_master_controller_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe,
    .sda_in(sda), .sda_out, .sda_oe, .irq);
  i2c_slave_model i2c_slave_model_i (.scl, .sda, .send(s_send), .nack(s_nack),
    .stretch(s_stretch), .tx_byte(8'h5a), .sda_low(s_sda_low), .scl_low(s_scl_low),
    .rx_byte(s_rx), .ack_seen(s_ack));
  // Clock, 4 ns
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // Period between the last two SCL rises
  always @(posedge scl) begin
    scl_per = $time - t_rise;
    t_rise = $time;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rdc(input logic [9:0] idx, input logic [31:0] e, input string n);
    apb(1'h0, idx, 32'h0);
    chk(n, e, rd);
  endtask : rdc
  // Poll the done flag, bounded
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'h0, `CTRL_IDX, 32'h0);
      n++;
    end while (rd[`DONE_BIT] !== 1'h1 && n < 3000);
    chk("byte done", 32'h1, {31'h0, rd[`DONE_BIT]});
  endtask : wait_done
  // Wait for SCL held low, or for a free bus, bounded
  task automatic wait_bus(input logic free);
    int n;
    n = 0;
    while ((free ? !(scl === 1'h1 && sda === 1'h1) : scl !== 1'h0) && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk("bus wait", 32'h1, {31'h0, n < 2000});
    repeat (8) @(posedge pclk);
  endtask : wait_bus
  task automatic results;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // Watchdog, well beyond the expected run
  initial begin
    #200000;
    num_errors++;
    results;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {s_send, s_nack, s_stretch} = 3'h0;
    {num_errors, check_count, t_rise} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    // Reset values, unmapped access, start while disabled
    rdc(`CTRL_IDX, 32'h4, "ctrl reset");
    rdc(`DATA_IDX, 32'h0, "data reset");
    rdc(`IEN_IDX, 32'h0, "irq enable reset");
    rdc(10'h0e5, 32'h0, "unmapped read");
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'h1, `CTRL_IDX, 32'h8);
    repeat (40) @(posedge pclk);
    chk("sda idle while off", 32'h1, {31'h0, sda});
    $display("test reset done");
    // Transmit one byte at each rate code
    apb(1'h1, `MASK_IDX, 32'h1);
    apb(1'h1, `IEN_IDX, 32'h80);
    apb(1'h1, `CTRL_IDX, 32'h88);
    wait_bus(1'h0);
    for (int r = 0; r < 4; r++) begin
      apb(1'h1, `CTRL_IDX, 32'h80 | 32'(r));
      rdc(`CTRL_IDX, 32'h80 | 32'(r), "ctrl after clear");
      apb(1'h1, `DATA_IDX, 32'ha0 + 32'(r));
      wait_done;
      lo = 64'h10 << (2 * r);
      chk("scl period", 32'h1, {31'h0, scl_per >= lo && scl_per <= lo + 16});
      chk("slave byte", 32'ha0 + 32'(r), {24'h0, s_rx});
      chk("ack in", 32'h0, {31'h0, rd[`ACKIN_BIT]});
      @(posedge pclk);
      chk("irq set", 32'h1, {31'h0, irq});
      rdc(`STAT_IDX, 32'h1, "status done");
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      chk("scl held", 32'h0, {31'h0, scl});
    end
    $display("test transmit done");
    // NACK from a stretching slave, irq gated by its enable
    apb(1'h1, `IEN_IDX, 32'h0);
    apb(1'h1, `CTRL_IDX, 32'h80);
    s_nack <= 1'h1;
    s_stretch <= 1'h1;
    apb(1'h1, `DATA_IDX, 32'h3c);
    wait_done;
    chk("ack in nack", 32'h1, {31'h0, rd[`ACKIN_BIT]});
    chk("stretched byte", 32'h3c, {24'h0, s_rx});
    @(posedge pclk);
    chk("irq gated", 32'h0, {31'h0, irq});
    apb(1'h1, `IEN_IDX, 32'h80);
    repeat (2) @(posedge pclk);
    chk("irq enabled", 32'h1, {31'h0, irq});
    rdc(`STAT_IDX, 32'h3, "status nack");
    s_nack <= 1'h0;
    s_stretch <= 1'h0;
    $display("test nack done");
    // Receive with ACK then NACK, then STOP
    apb(1'h1, `CTRL_IDX, 32'h80);
    s_send <= 1'h1;
    apb(1'h0, `DATA_IDX, 32'h0);
    wait_done;
    chk("master ack", 32'h0, {31'h0, s_ack});
    apb(1'h1, `CTRL_IDX, 32'hc0);
    rdc(`DATA_IDX, 32'h5a, "rx byte");
    wait_done;
    chk("master nack", 32'h1, {31'h0, s_ack});
    s_send <= 1'h0;
    apb(1'h1, `CTRL_IDX, 32'h84);
    wait_bus(1'h1);
    apb(1'h0, `CTRL_IDX, 32'h0);
    chk("stop bit", 32'h1, {31'h0, rd[`STOP_BIT]});
    $display("test receive done");
    // Disable in mid-byte releases both lines
    apb(1'h1, `CTRL_IDX, 32'h0);
    apb(1'h1, `CTRL_IDX, 32'h88);
    wait_bus(1'h0);
    apb(1'h1, `DATA_IDX, 32'hff);
    repeat (10) @(posedge pclk);
    apb(1'h1, `CTRL_IDX, 32'h0);
    repeat (4) @(posedge pclk);
    chk("lines free", 32'h3, {30'h0, scl, sda});
    $display("test abort done");
    results;
  end
endmodule : testbench
